// ==== logic/crp_pkg.sv ====
// Package of the chip reset pin control block: timing counts, carriers, states.
// Assumes a 10 MHz system clock.
package crp_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS      = 100;
   localparam int unsigned HARD_MIN_NS        = 1000;
   localparam int unsigned HARD_MIN_CYC       = (HARD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DRIVE_NS           = 10000;
   localparam int unsigned DRIVE_CYC          = DRIVE_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W              = 8;
   localparam int unsigned CFG_W              = 4;
   localparam logic [CFG_W-1:0] CFG_RST       = 4'h0;

   // ************************************************************
   // Carriers and states
   // ************************************************************
   typedef struct packed {
      logic watchdog;
      logic wake;
      logic dram;
      logic software;
   } crp_src_s;

   typedef struct packed {
      logic o;
      logic oe;
   } crp_pin_s;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_EXT   = 2'b01,
      ST_DRIVE = 2'b10,
      ST_WAIT  = 2'b11
   } crp_state_e;

endpackage

// ==== logic/crp_top.sv ====
// Reset pin control: open-drain hard reset line, power-on reset, boot configuration capture.
// Assumes reset source pulses come from logic on clk_sys_i; pins are asynchronous.
//
// Overview of operation
// R01: Hard reset line is open drain; external assertion resets the chip synchronously.
// R02: External agent holds the hard reset line low at least the minimum time.
// R03: Power-on, hard, watchdog, wake-up and DRAM resets drive the line fixed time; code takes requests only in ST_RUN, a pulse in ST_EXT is lost.
// R04: Software reset drives the line only when its enable input is set.
// R05: Power-on reset low resets all logic asynchronously.
// R06: Power-on reset is level sensitive; logic stays reset while it is low.
// R07: Four configuration inputs are sampled at hardware reset and select boot option.
// R08: External reset is synchronised; internal reset released synchronously after drive period.
`timescale 1ns/1ps
module crp_top
   import crp_pkg::*;
(
   // Clock and power-on reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   // Hard reset line, three signals
   input  wire logic             hard_reset_in_i,
   output logic                  hard_reset_o,
   output logic                  hard_reset_oe_o,
   // Internal reset requests
   input  wire crp_src_s         src_i,
   input  wire logic             sw_drive_en_i,
   // Configuration straps
   input  wire logic [CFG_W-1:0] cfg_i,
   // Results
   output logic                  chip_reset_n_o,
   output logic [CFG_W-1:0]      boot_cfg_o
);

   // ************************************************************
   // Reset release and pin synchronisers
   // ************************************************************
   logic             rst_s1_q, rst_n_q;
   logic             hr_s1_q, hr_q;
   logic [CFG_W-1:0] cfg_s1_q, cfg_q;

   // Assertion is immediate; release waits two edges. [R05] [R06]
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // The line idles high; resetting the synchroniser high avoids a false request. [R08]
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hr_s1_q  <= 1'b1;
         hr_q     <= 1'b1;
         cfg_s1_q <= CFG_RST;
         cfg_q    <= CFG_RST;
      end else begin
         hr_s1_q  <= hard_reset_in_i;
         hr_q     <= hr_s1_q;
         cfg_s1_q <= cfg_i;
         cfg_q    <= cfg_s1_q;
      end
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   crp_state_e       state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             req_int;

   // Software reset only reaches the pin when enabled. [R03] [R04]
   assign req_int = src_i.watchdog | src_i.wake | src_i.dram | (src_i.software & sw_drive_en_i);

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      unique case (state_q)
         ST_RUN: begin
            if (req_int) begin
               state_d = ST_DRIVE;
               cnt_d   = CNT_W'(DRIVE_CYC - 1);
            end else if (!hr_q) begin
               // Short glitches are filtered by the minimum time count. [R01] [R02]
               state_d = ST_EXT;
               cnt_d   = CNT_W'(HARD_MIN_CYC - 1);
            end
         end
         ST_EXT: begin
            if (hr_q) begin
               state_d = ST_RUN;
            end else if (cnt_q == '0) begin
               // A recognised hard reset is answered by driving the line too. [R03]
               state_d = ST_DRIVE;
               cnt_d   = CNT_W'(DRIVE_CYC - 1);
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         ST_DRIVE: begin
            if (cnt_q == '0) begin
               state_d = ST_WAIT;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         ST_WAIT: begin
            // Hold reset while someone outside still pulls the line low. [R08]
            if (hr_q) begin
               state_d = ST_RUN;
            end
         end
      endcase
   end

   // Power-on starts in the driving phase so the line is asserted after power-up. [R03]
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_DRIVE;
         cnt_q   <= CNT_W'(DRIVE_CYC - 1);
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Open drain: output value is always low, only the enable moves. [R01]
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hard_reset_o    <= 1'b0;
         hard_reset_oe_o <= 1'b1;
         chip_reset_n_o  <= 1'b0;
      end else begin
         hard_reset_o    <= 1'b0;
         hard_reset_oe_o <= (state_d == ST_DRIVE);
         // A low wire that is still being timed is not yet a reset, so the chip keeps running. [R01] [R02] [R08]
         chip_reset_n_o  <= (state_d == ST_RUN) || (state_d == ST_EXT);
      end
   end

   // Straps are taken while the chip is held in reset, frozen once it runs. [R07]
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         boot_cfg_o <= CFG_RST;
      end else if ((state_q == ST_DRIVE) || (state_q == ST_WAIT)) begin
         boot_cfg_o <= cfg_q;
      end
   end

endmodule

// ==== testbench/crp_partner.sv ====
// Reset supervisor model on the hard reset wire.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
module crp_partner (
   input  wire logic clk_i,
   output logic      pull_n_o
);
   initial pull_n_o = 1'b1;
   // Holds the wire low for whole cycles, then lets the pull-up restore it.
   task automatic pull(input int n);
      pull_n_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      pull_n_o <= 1'b1;
   endtask
endmodule

// ==== testbench/crp_top_sva.sv ====
// Checker of the reset pin block.
// Assumes it is bound to crp_top and sees only its ports.
`timescale 1ns/1ps
module crp_top_sva
   import crp_pkg::*;
(
   input wire logic             clk_sys_i, rst_n_i, hard_reset_in_i, hard_reset_o, hard_reset_oe_o,
   input wire logic             sw_drive_en_i, chip_reset_n_o,
   input wire crp_src_s         src_i,
   input wire logic [CFG_W-1:0] cfg_i, boot_cfg_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   property p_od; !hard_reset_o; endproperty
   a_od: assert property (p_od) else $error("pin driven high");
   property p_wd; chip_reset_n_o && src_i.watchdog |=> hard_reset_oe_o && !chip_reset_n_o; endproperty
   a_wd: assert property (p_wd) else $error("watchdog ignored");
   property p_swe; chip_reset_n_o && src_i.software && sw_drive_en_i |=> hard_reset_oe_o; endproperty
   a_swe: assert property (p_swe) else $error("software drive missing");
   property p_swd; chip_reset_n_o && src_i == 4'h1 && !sw_drive_en_i |=> chip_reset_n_o && !hard_reset_oe_o; endproperty
   a_swd: assert property (p_swd) else $error("software drove line");
   property p_len; $rose(hard_reset_oe_o) |-> ##99 hard_reset_oe_o ##1 !hard_reset_oe_o; endproperty
   a_len: assert property (p_len) else $error("drive length wrong");
   property p_hold; hard_reset_oe_o |-> !chip_reset_n_o; endproperty
   a_hold: assert property (p_hold) else $error("chip ran while driving");
   property p_rel; $rose(chip_reset_n_o) |-> $past(hard_reset_in_i, 2); endproperty
   a_rel: assert property (p_rel) else $error("released with line low");
   property p_boot; chip_reset_n_o && $past(chip_reset_n_o) |-> $stable(boot_cfg_o); endproperty
   a_boot: assert property (p_boot) else $error("boot cfg moved");
endmodule
bind crp_top crp_top_sva u_sva (.*);

// ==== testbench/crp_top_tb_top.sv ====
// Bench of the reset pin block with a supervisor model.
// Assumes the drive and minimum counts of the package.
`timescale 1ns/1ps
module crp_top_tb_top;
   import crp_pkg::*;
   logic             clk_sys_i = 0, rst_n_i = 0, en = 0, pull_n, oe, o, chip_n, wire_w;
   crp_src_s         src = '0;
   logic [CFG_W-1:0] cfg = '0, boot, keep, v;
   int               bad_count = 0, total_checks = 0, cyc = 0, seed = 17556, n, m;
   assign wire_w = pull_n & ~(oe & ~o);
   initial forever #50 clk_sys_i = ~clk_sys_i;
   crp_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hard_reset_in_i(wire_w), .hard_reset_o(o),
      .hard_reset_oe_o(oe), .src_i(src), .sw_drive_en_i(en), .cfg_i(cfg), .chip_reset_n_o(chip_n),
      .boot_cfg_o(boot));
   crp_partner sup (.clk_i(clk_sys_i), .pull_n_o(pull_n));
   task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // A negative count skips the drive length, whose start differs after power-on.
   task automatic run(input int exp);
      n = 0;
      m = 0;
      repeat (150) @(negedge clk_sys_i) begin
         n += (oe === 1'b1);
         m += (chip_n !== 1'b1);
      end
      if (exp >= 0) chk("drive cycles", 8'(n), 8'(exp));
      if (exp == 0) chk("ignored request reset", 8'(m), 8'h00);
      repeat (20) @(negedge clk_sys_i);
      chk("chip reset", chip_n, 1'b1);
      chk("boot cfg", boot, keep);
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      cfg = 4'($random(seed));
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      keep = cfg;
      run(-1);
      // Cases 0 to 3 are internal sources, 4 software without enable, 5 and 6 external pulls.
      for (int k = 0; k < 7; k++) begin
         @(posedge clk_sys_i);
         v = 4'($random(seed));
         cfg <= v;
         en <= (k != 4);
         if (k < 5) src <= crp_src_s'(k < 4 ? 4'h8 >> k : 4'h1);
         @(posedge clk_sys_i);
         src <= '0;
         if (k > 4) fork sup.pull(k == 5 ? HARD_MIN_CYC + 4 : 5); join_none
         if (k != 4 && k != 6) keep = v;
         run((k != 4 && k != 6) ? DRIVE_CYC : 0);
         $display("test %0d done", k);
      end
      // Power-on reset is applied between edges to show it does not wait for the clock.
      @(negedge clk_sys_i);
      rst_n_i = 1'b0;
      #1 chk("async reset", {oe, chip_n}, 2'b10);
      repeat (3) @(negedge clk_sys_i) chk("reset level", chip_n, 1'b0);
      @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      keep = cfg;
      run(-1);
      summarize();
   end
endmodule
